/* File: core/lcc_charger_ctrl.sv */
// charger control state machine with wishbone register file
`timescale 1ns/1ps
`default_nettype none
module lcc_charger_ctrl
    import lcc_pkg::*;
#(
    parameter logic [32:0] MINUTE_CYCLES = 33'(MINUTE_CYC)
) (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // wishbone classic slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // analog comparators and pins, asynchronous
    input  wire logic        i_vin_above_bat,
    input  wire logic        i_vin_above_uvlo,
    input  wire logic        i_bat_above_precond,
    input  wire logic        i_bat_at_term,
    input  wire logic        i_eoc_below,
    input  wire logic        i_bat_restart,
    input  wire logic        i_current_level_pin,
    input  wire logic        i_current_level_float,
    input  wire logic        i_other_fault,
    // analog loop controls
    output logic             o_charge_en,
    output logic             o_precond_mode,
    output logic             o_cv_mode,
    output logic             o_use_second,
    output logic      [3:0]  o_first_setting,
    output logic      [2:0]  o_second_setting,
    // open-drain status pin
    output logic             o_status_od_o,
    output logic             o_status_od_oe,
    // interrupt
    output logic             o_irq
);

    // ************************************************************************
    // input synchronisation
    // ************************************************************************
    logic [SI_W-1:0] raw_in;
    logic [SI_W-1:0] s_in;
    assign raw_in = {i_other_fault, i_current_level_float, i_current_level_pin,
                     i_bat_restart, i_eoc_below, i_bat_at_term, i_bat_above_precond,
                     i_vin_above_uvlo, i_vin_above_bat};
    lcc_sync2 #(.WIDTH(SI_W)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_async   (raw_in),
        .o_sync    (s_in)
    );

    // ************************************************************************
    // register state
    // ************************************************************************
    logic [3:0]       first_current_setting;
    logic [2:0]       second_current_setting;
    logic [1:0]       timeout_select_field;
    logic             suspend_charging_bit;
    logic             current_select_bit;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic             ack;
    logic [31:0]      rdata;
    logic [3:0]       next_first_current_setting;
    logic [2:0]       next_second_current_setting;
    logic [1:0]       next_timeout_select_field;
    logic             next_suspend_charging_bit;
    logic             next_current_select_bit;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_mask;
    logic             next_ack;
    logic [31:0]      next_rdata;

    // ************************************************************************
    // charger state
    // ************************************************************************
    lcc_state_t  state;
    lcc_state_t  next_state;
    logic [32:0] presc;
    logic [32:0] next_presc;
    logic [6:0]  minutes;
    logic [6:0]  next_minutes;
    logic        timeout_fault_bit;
    logic        next_timeout_fault_bit;
    logic        supply_prev;
    logic        next_supply_prev;
    logic        input_supply_good_bit;
    logic        charger_ok_bit;
    logic        charging_status_bit;
    logic        blocked;
    logic        run_ok;
    logic        tick;
    logic        restart_count;
    logic        tmo_off;
    logic [6:0]  tmo_limit;
    logic [IRQ_W-1:0] events;

    // ************************************************************************
    // status decode
    // ************************************************************************
    assign input_supply_good_bit = s_in[SI_ABOVE_BAT] & s_in[SI_ABOVE_UVLO];
    assign charger_ok_bit = input_supply_good_bit & ~s_in[SI_FAULT]
                          & ~timeout_fault_bit;
    assign blocked = s_in[SI_FLOAT] | suspend_charging_bit | s_in[SI_FAULT]
                   | timeout_fault_bit;
    // enable needs both supply comparators and no float, suspend, fault or timeout; no external detect signal
    assign run_ok = input_supply_good_bit & ~blocked;
    assign charging_status_bit = (state == ST_PRECOND) | (state == ST_FAST)
                               | (state == ST_TOPOFF);
    assign tick = (presc == MINUTE_CYCLES - 33'h1);
    always_comb begin
        tmo_off   = 1'b0;
        tmo_limit = TMO_60_MIN;
        case (timeout_select_field)
            TSEL_60:  tmo_limit = TMO_60_MIN;
            TSEL_90:  tmo_limit = TMO_90_MIN;
            TSEL_120: tmo_limit = TMO_120_MIN;
            TSEL_OFF: tmo_off   = 1'b1;
            default:  tmo_limit = TMO_60_MIN;
        endcase
    end

    // ************************************************************************
    // charger state machine and timers
    // ************************************************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_SUSPEND: begin
                if (run_ok) begin
                    next_state = ST_PRECOND;
                end
            end
            ST_PRECOND: begin
                if (!run_ok) begin
                    next_state = ST_SUSPEND;
                end else if (s_in[SI_PRECOND_OK]) begin
                    next_state = ST_FAST;
                end else if (!tmo_off && minutes == tmo_limit) begin
                    next_state = ST_TFAULT;
                end
            end
            ST_FAST: begin
                if (!run_ok) begin
                    next_state = ST_SUSPEND;
                end else if (s_in[SI_AT_TERM]) begin
                    next_state = ST_TOPOFF;
                end
            end
            ST_TOPOFF: begin
                if (!run_ok) begin
                    next_state = ST_SUSPEND;
                end else if (minutes == EOC_MIN) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!run_ok) begin
                    next_state = ST_SUSPEND;
                end else if (s_in[SI_RESTART]) begin
                    next_state = ST_PRECOND;
                end
            end
            ST_TFAULT: begin
                // no direct path back to charging, only through suspend
                if (!input_supply_good_bit || suspend_charging_bit) begin
                    next_state = ST_SUSPEND;
                end
            end
            default: next_state = ST_SUSPEND;
        endcase
        // minute counter restarts on every state entry, so the safety timer
        // only ever measures time spent in precondition
        restart_count = (next_state != state)
                      || (state == ST_TOPOFF && !s_in[SI_EOC]);
        if (restart_count || tick) begin
            next_presc = '0;
        end else begin
            next_presc = presc + 33'h1;
        end
        if (restart_count) begin
            next_minutes = '0;
        end else if (tick && (state == ST_PRECOND || state == ST_TOPOFF)
                     && minutes != 7'h7F) begin
            next_minutes = minutes + 7'h1;
        end else begin
            next_minutes = minutes;
        end
        next_timeout_fault_bit = (next_state == ST_TFAULT);
        next_supply_prev       = input_supply_good_bit;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state             <= ST_SUSPEND;
            presc             <= '0;
            minutes           <= '0;
            timeout_fault_bit <= 1'b0;
            supply_prev       <= 1'b0;
        end else begin
            state             <= next_state;
            presc             <= next_presc;
            minutes           <= next_minutes;
            timeout_fault_bit <= next_timeout_fault_bit;
            supply_prev       <= next_supply_prev;
        end
    end

    // ************************************************************************
    // register file and wishbone slave
    // ************************************************************************
    logic       wr_en;
    logic [5:0] idx;
    logic [7:0] wbyte;
    assign idx   = i_wb_adr[7:2];
    assign wbyte = i_wb_dat[7:0];
    // a write lands on the edge where the master sees ack
    assign wr_en = i_wb_cyc & i_wb_stb & i_wb_we & ack & i_wb_sel[0];
    assign events[IRQ_TFLT_BIT]   = (next_state == ST_TFAULT) && (state != ST_TFAULT);
    assign events[IRQ_DONE_BIT]   = (next_state == ST_SLEEP) && (state != ST_SLEEP);
    assign events[IRQ_SUPPLY_BIT] = input_supply_good_bit ^ supply_prev;

    always_comb begin
        next_first_current_setting  = first_current_setting;
        next_second_current_setting = second_current_setting;
        next_timeout_select_field   = timeout_select_field;
        next_suspend_charging_bit   = suspend_charging_bit;
        next_current_select_bit     = current_select_bit;
        next_irq_mask               = irq_mask;
        next_irq_stat               = irq_stat;
        if (wr_en) begin
            case (idx)
                IDX_FIRST_CURRENT_SETTING: next_first_current_setting = wbyte[3:0];
                IDX_SECOND_CURRENT_SETTING: next_second_current_setting =
                               wbyte[SECOND_CURRENT_SETTING_LSB+:3];
                IDX_TIMER: next_timeout_select_field = wbyte[TIMER_TSEL_LSB+:2];
                IDX_CTRL: begin
                    next_suspend_charging_bit = wbyte[CTRL_SUSP_BIT];
                    next_current_select_bit   = wbyte[CTRL_SEL_BIT];
                end
                IDX_IRQ_STAT: next_irq_stat = irq_stat & ~wbyte[IRQ_W-1:0];
                IDX_IRQ_MASK: next_irq_mask = wbyte[IRQ_W-1:0];
                default: next_irq_mask = irq_mask;
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_irq_stat = next_irq_stat | events;
        next_ack   = i_wb_cyc & i_wb_stb & ~ack;
        next_rdata = '0;
        case (idx)
            IDX_FIRST_CURRENT_SETTING: next_rdata[3:0] = first_current_setting;
            IDX_SECOND_CURRENT_SETTING: next_rdata[SECOND_CURRENT_SETTING_LSB+:3] = second_current_setting;
            IDX_TIMER: begin
                next_rdata[TIMER_CHARGING_STATUS_BIT_BIT]  = charging_status_bit;
                next_rdata[TIMER_TFLT_BIT]     = timeout_fault_bit;
                next_rdata[TIMER_TSEL_LSB+:2]  = timeout_select_field;
            end
            IDX_CTRL: begin
                next_rdata[CTRL_SUSP_BIT]  = suspend_charging_bit;
                next_rdata[CTRL_OK_BIT]    = charger_ok_bit;
                next_rdata[CTRL_SEL_BIT]   = current_select_bit;
                next_rdata[CTRL_VINOK_BIT] = input_supply_good_bit;
            end
            IDX_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
            IDX_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
            default:      next_rdata = '0;
        endcase
        if (!next_ack) begin
            next_rdata = rdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            first_current_setting  <= FIRST_CURRENT_SETTING_RST;
            second_current_setting <= SECOND_CURRENT_SETTING_RST;
            timeout_select_field   <= TSEL_RST;
            suspend_charging_bit   <= SUSP_RST;
            current_select_bit     <= SEL_RST;
            irq_stat               <= '0;
            irq_mask               <= MASK_RST;
            ack                    <= 1'b0;
            rdata                  <= '0;
        end else begin
            first_current_setting  <= next_first_current_setting;
            second_current_setting <= next_second_current_setting;
            timeout_select_field   <= next_timeout_select_field;
            suspend_charging_bit   <= next_suspend_charging_bit;
            current_select_bit     <= next_current_select_bit;
            irq_stat               <= next_irq_stat;
            irq_mask               <= next_irq_mask;
            ack                    <= next_ack;
            rdata                  <= next_rdata;
        end
    end

    // ************************************************************************
    // outputs
    // ************************************************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_charge_en    <= 1'b0;
            o_precond_mode <= 1'b0;
            o_cv_mode      <= 1'b0;
            o_use_second   <= 1'b0;
            o_status_od_oe <= 1'b0;
            o_irq          <= 1'b0;
        end else begin
            o_charge_en    <= charging_status_bit;
            o_precond_mode <= (state == ST_PRECOND);
            o_cv_mode      <= (state == ST_TOPOFF);
            // either source high picks the second setting; register-only use
            // relies on the level pin being grounded
            o_use_second   <= s_in[SI_LEVEL] | current_select_bit;
            o_status_od_oe <= charging_status_bit;
            o_irq          <= |(irq_stat & irq_mask);
        end
    end

    assign o_wb_ack         = ack;
    assign o_wb_dat         = rdata;
    assign o_first_setting  = first_current_setting;
    assign o_second_setting = second_current_setting;
    assign o_status_od_o    = 1'b0;

endmodule
`default_nettype wire

/* File: core/lcc_pkg.sv */
// constants, register map and types of the lithium cell charger control block
// ****************************************************************************
// ****************************************************************************
package lcc_pkg;

    // ************************************************************************
    // register indices, byte address is four times the index
    // ************************************************************************
    localparam logic [5:0] IDX_FIRST_CURRENT_SETTING    = 6'h08;
    localparam logic [5:0] IDX_TIMER    = 6'h09;
    localparam logic [5:0] IDX_SECOND_CURRENT_SETTING    = 6'h0A;
    localparam logic [5:0] IDX_CTRL     = 6'h0B;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h0C;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h0D;

    // ************************************************************************
    // field positions
    // ************************************************************************
    localparam int TIMER_CHARGING_STATUS_BIT_BIT = 0;
    localparam int TIMER_TFLT_BIT    = 3;
    localparam int TIMER_TSEL_LSB    = 6;
    localparam int SECOND_CURRENT_SETTING_LSB         = 4;
    localparam int CTRL_SUSP_BIT     = 0;
    localparam int CTRL_OK_BIT       = 1;
    localparam int CTRL_SEL_BIT      = 2;
    localparam int CTRL_VINOK_BIT    = 4;
    localparam int IRQ_TFLT_BIT      = 0;
    localparam int IRQ_DONE_BIT      = 1;
    localparam int IRQ_SUPPLY_BIT    = 2;
    localparam int IRQ_W             = 3;

    // ************************************************************************
    // reset values
    // ************************************************************************
    localparam logic [3:0]       FIRST_CURRENT_SETTING_RST = 4'h0;
    localparam logic [2:0]       SECOND_CURRENT_SETTING_RST = 3'h0;
    localparam logic [1:0]       TSEL_RST  = 2'h0;
    localparam logic             SUSP_RST  = 1'b0;
    localparam logic             SEL_RST   = 1'b0;
    localparam logic [IRQ_W-1:0] MASK_RST  = 3'h0;

    // ************************************************************************
    // timeout select codes
    // ************************************************************************
    localparam logic [1:0] TSEL_60  = 2'h0;
    localparam logic [1:0] TSEL_90  = 2'h1;
    localparam logic [1:0] TSEL_120 = 2'h2;
    localparam logic [1:0] TSEL_OFF = 2'h3;

    // ************************************************************************
    // timing
    // ************************************************************************
    localparam longint     CLK_HZ      = 100_000_000;
    localparam longint     SEC_PER_MIN = 60;
    localparam longint     MINUTE_CYC  = CLK_HZ * SEC_PER_MIN;
    localparam logic [6:0] TMO_60_MIN  = 7'd60;
    localparam logic [6:0] TMO_90_MIN  = 7'd90;
    localparam logic [6:0] TMO_120_MIN = 7'd120;
    localparam logic [6:0] EOC_MIN     = 7'd4;

    // ************************************************************************
    // synchronised input vector positions
    // ************************************************************************
    localparam int SI_ABOVE_BAT  = 0;
    localparam int SI_ABOVE_UVLO = 1;
    localparam int SI_PRECOND_OK = 2;
    localparam int SI_AT_TERM    = 3;
    localparam int SI_EOC        = 4;
    localparam int SI_RESTART    = 5;
    localparam int SI_LEVEL      = 6;
    localparam int SI_FLOAT      = 7;
    localparam int SI_FAULT      = 8;
    localparam int SI_W          = 9;

    typedef enum logic [2:0] {
        ST_SUSPEND,
        ST_PRECOND,
        ST_FAST,
        ST_TOPOFF,
        ST_SLEEP,
        ST_TFAULT
    } lcc_state_t;

endpackage

/* File: core/lcc_sync2.sv */
// two-flop synchroniser for a vector of independent level inputs
`timescale 1ns/1ps
`default_nettype none
module lcc_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    // levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;

    // the first stage feeds only the second
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule
`default_nettype wire

/* File: verification/lcc_ctrl_sva.sv */
// port checker for the charger control block
`timescale 1ns/1ps
`default_nettype none
module lcc_ctrl_sva (
    // clock, reset, inputs
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_current_level_pin,
    input wire logic i_current_level_float,
    input wire logic i_vin_above_uvlo,
    // outputs
    input wire logic o_wb_ack,
    input wire logic o_charge_en,
    input wire logic o_precond_mode,
    input wire logic o_cv_mode,
    input wire logic o_use_second,
    input wire logic o_status_od_oe
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    // five samples leave room for two sync flops plus state and output flops
    sequence s_float_held;
        i_current_level_float [*5];
    endsequence
    a_ack_answer: assert property (s_req |=> o_wb_ack)
        else $error("request not acknowledged");
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held too long");
    a_sink_tracks: assert property (o_status_od_oe == o_charge_en)
        else $error("status sink differs from charging");
    a_mode_charges: assert property ((o_precond_mode || o_cv_mode) |-> o_charge_en)
        else $error("mode flag without charging");
    a_modes_apart: assert property (!(o_precond_mode && o_cv_mode))
        else $error("two charge modes at once");
    a_float_blocks: assert property (s_float_held |=> !o_charge_en)
        else $error("charging with floating level pin");
    a_uvlo_blocks: assert property (!i_vin_above_uvlo [*5] |=> !o_status_od_oe)
        else $error("charging without valid supply");
    a_pin_second: assert property (i_current_level_pin [*4] |=> o_use_second)
        else $error("high level pin not selecting second");
endmodule
bind lcc_charger_ctrl lcc_ctrl_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_current_level_pin(i_current_level_pin),
    .i_current_level_float(i_current_level_float), .i_vin_above_uvlo(i_vin_above_uvlo),
    .o_wb_ack(o_wb_ack), .o_charge_en(o_charge_en), .o_precond_mode(o_precond_mode),
    .o_cv_mode(o_cv_mode), .o_use_second(o_use_second), .o_status_od_oe(o_status_od_oe));
`default_nettype wire

/* File: verification/lcc_afe_model.sv */
// analog front end and level pin driver model
`timescale 1ns/1ps
`default_nettype none
module lcc_afe_model (
    input  wire logic       i_ref_clk,
    input  wire logic [8:0] i_want,
    output logic      [8:0] o_lv
);
    // level pin rests low so the select bit alone picks the current
    initial o_lv = 9'h000;
    always @(posedge i_ref_clk) o_lv <= i_want;
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the charger control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int MC = 2;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [8:0] want = 9'h000, lv;
    logic ack, chg, pre, cv, sec, oe, od, irq;
    logic [3:0] s1o;
    logic [2:0] s2o;
    int err_count = 0, n_checks = 0, c, s, seed = 32'h7ABF;
    int lim[3] = '{60, 90, 120};
    int mdl[16] = '{default: 0}, rwm[16] = '{default: 0};
    initial forever #5 clk = ~clk;
    lcc_afe_model afe (.i_ref_clk(clk), .i_want(want), .o_lv(lv));
    lcc_charger_ctrl #(.MINUTE_CYCLES(33'(MC))) DUT (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
        .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack), .i_vin_above_bat(lv[0]),
        .i_vin_above_uvlo(lv[1]), .i_bat_above_precond(lv[2]), .i_bat_at_term(lv[3]),
        .i_eoc_below(lv[4]), .i_bat_restart(lv[5]), .i_current_level_pin(lv[6]),
        .i_current_level_float(lv[7]), .i_other_fault(lv[8]), .o_charge_en(chg),
        .o_precond_mode(pre), .o_cv_mode(cv), .o_use_second(sec), .o_first_setting(s1o),
        .o_second_setting(s2o), .o_status_od_o(od), .o_status_od_oe(oe), .o_irq(irq));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask
    // request held until the edge that sees ack, released right after it
    task automatic bus(input logic w, input int i, input int d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= 8'(i * 4);
        wd <= 32'(d);
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t no bus answer", $time);
            end_of_test();
        end
    endtask
    task automatic wr(input int i, input int d);
        bus(1'b1, i, d);
        mdl[i] = i == 12 ? mdl[i] & ~d : (mdl[i] & ~rwm[i]) | (d & rwm[i]);
    endtask
    task automatic rd(input int i);
        bus(1'b0, i, 0);
        chk(q, 32'(mdl[i]));
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        rwm[8] = 15;
        rwm[9] = 192;
        rwm[10] = 112;
        rwm[11] = 5;
        rwm[13] = 7;
        tk(4);
        rst_n <= 1'b1;
        for (c = 0; c < 16; c++) begin
            rd(c);
        end
        chk(sec, 0);
        s = $random(seed);
        wr(8, s & 15);
        wr(10, s & 112);
        rd(8);
        rd(10);
        chk(s1o, s & 15);
        chk(s2o, (s >> 4) & 7);
        wr(11, 4);
        tk(3);
        chk(sec, 1);
        wr(11, 1);
        tk(3);
        chk(sec, 0);
        want[6] <= 1'b1;
        tk(6);
        chk(sec, 1);
        want[6] <= 1'b0;
        want[1:0] <= 2'b11;
        tk(8);
        mdl[11] = 8'h13;
        mdl[12] = 4;
        rd(11);
        chk(chg, 0);
        rd(12);
        wr(13, 4);
        tk(2);
        chk(irq, 1);
        wr(12, 4);
        tk(2);
        chk(irq, 0);
        // each timeout code, the last one never expires
        for (c = 0; c < 4; c++) begin
            wr(9, c << 6);
            wr(11, 0);
            tk((c < 3 ? lim[c] : 130) * MC - 6);
            chk({oe, od, pre}, 5);
            tk(12);
            mdl[9] = c < 3 ? (c << 6) | 8 : 193;
            rd(9);
            wr(11, 1);
            tk(4);
            mdl[9] = c << 6;
            rd(9);
        end
        wr(9, 0);
        mdl[12] = 1;
        rd(12);
        want[2] <= 1'b1;
        wr(11, 0);
        tk(130 * MC);
        chk({chg, pre}, 2);
        want[3] <= 1'b1;
        tk(8);
        chk(cv, 1);
        // end of charge held four minutes ends the cycle, restart charges again
        want[4] <= 1'b1;
        tk(4 * MC + 8);
        chk({chg, cv}, 0);
        mdl[12] = 3;
        rd(12);
        want[4] <= 1'b0;
        want[5] <= 1'b1;
        tk(8);
        chk({chg, oe}, 3);
        want[5] <= 1'b0;
        want[7] <= 1'b1;
        tk(8);
        chk(chg, 0);
        rd(9);
        want[7] <= 1'b0;
        tk(8);
        chk(chg, 1);
        want[8] <= 1'b1;
        tk(8);
        mdl[11] = 8'h10;
        rd(11);
        chk(chg, 0);
        want[8] <= 1'b0;
        want[1] <= 1'b0;
        tk(8);
        mdl[11] = 0;
        rd(11);
        chk({chg, irq}, 1);
        end_of_test();
    end
endmodule
`default_nettype wire
